// >>> design/cascaded_channel_divider.v
// Two-stage cascaded output channel divider with AXI4-Lite register access
//
// The AXI4-Lite register port was chosen for this implementation.
`include "cascaded_channel_divider_map.vh"

module cascaded_channel_divider (
   input  wire        aclk,
   input  wire        aresetn,
   input  wire [11:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [11:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire        dist_clk,
   input  wire        sync_req,
   output reg         channel_out,
   output reg         duty_correction_active
);

   reg  [7:0] first_stage_cycle_counts;
   reg  [7:0] stage_phase_offsets;
   reg  [7:0] second_stage_cycle_counts;
   reg  [7:0] channel_divider_control;
   reg  [7:0] duty_correction_control;

   reg        dist_q;
   reg        first_level;
   reg  [4:0] first_count;
   reg        second_level;
   reg  [4:0] second_count;
   reg        first_src_q;
   reg        sync_seen;

   wire       bypass_second   = channel_divider_control[`BIT_BYPASS_SECOND];
   wire       bypass_first    = channel_divider_control[`BIT_BYPASS_FIRST];
   wire       ignore_sync     = channel_divider_control[`BIT_IGNORE_SYNC];
   wire       force_level     = channel_divider_control[`BIT_FORCE_LEVEL];
   wire       start_high_2nd  = channel_divider_control[`BIT_START_HIGH_2ND];
   wire       start_high_1st  = channel_divider_control[`BIT_START_HIGH_1ST];
   wire       duty_correction_disable = duty_correction_control[`BIT_DUTY_CORR_DIS];

   wire [3:0] first_low   = first_stage_cycle_counts[`LOW_FIELD_MSB:`LOW_FIELD_LSB];
   wire [3:0] first_high  = first_stage_cycle_counts[`HIGH_FIELD_MSB:`HIGH_FIELD_LSB];
   wire [3:0] second_low  = second_stage_cycle_counts[`LOW_FIELD_MSB:`LOW_FIELD_LSB];
   wire [3:0] second_high = second_stage_cycle_counts[`HIGH_FIELD_MSB:`HIGH_FIELD_LSB];
   wire [3:0] first_phase  = stage_phase_offsets[`HIGH_FIELD_MSB:`HIGH_FIELD_LSB];
   wire [3:0] second_phase = stage_phase_offsets[`LOW_FIELD_MSB:`LOW_FIELD_LSB];

   // Counter step: at zero toggle level and reload the next half period
   function [5:0] stage_step;
      input       level;
      input [4:0] cnt;
      input [3:0] high_m1;
      input [3:0] low_m1;
      begin
         if (cnt == 5'h00) begin
            if (level)
               stage_step = {1'b0, 1'b0, low_m1};
            else
               stage_step = {1'b1, 1'b0, high_m1};
         end else begin
            stage_step = {level, cnt - 5'h01};
         end
      end
   endfunction

   // Load after sync: start level, first half stretched by the phase offset
   function [5:0] stage_load;
      input       start_high;
      input [3:0] high_m1;
      input [3:0] low_m1;
      input [3:0] phase;
      begin
         if (start_high)
            stage_load = {1'b1, {1'b0, high_m1} + {1'b0, phase}};
         else
            stage_load = {1'b0, {1'b0, low_m1} + {1'b0, phase}};
      end
   endfunction

   // Register file index decode
   function mapped;
      input [9:0] idx;
      begin
         mapped = (idx >= `IDX_FIRST_STAGE_CYCLE_COUNTS) && (idx <= `IDX_CHANNEL_STATUS);
      end
   endfunction

   // Zero extension of an eight-bit register to a bus word
   function [31:0] reg_word;
      input [7:0] value;
      begin
         reg_word = {24'h000000, value};
      end
   endfunction

   // Divider datapath; bypassed stages pass their input straight on
   wire       sync_hold   = sync_req & ~ignore_sync;
   wire       dist_rise   = dist_clk & ~dist_q;
   wire       first_src   = bypass_first ? dist_q : first_level;
   wire       second_tick = first_src & ~first_src_q;
   wire       second_src  = bypass_second ? first_src : second_level;
   wire [5:0] first_next  = stage_step(first_level, first_count, first_high, first_low);
   wire [5:0] second_next = stage_step(second_level, second_count, second_high, second_low);
   wire [5:0] first_init  = stage_load(start_high_1st, first_high, first_low, first_phase);
   wire [5:0] second_init = stage_load(start_high_2nd, second_high, second_low, second_phase);

   // Status: sync seen, second stage, first stage, channel output
   wire [3:0] status_bits = {sync_seen, second_src, first_src, channel_out};

   // Input edge detection and sync history
   always @(posedge aclk) begin
      if (!aresetn) begin
         dist_q      <= 1'b0;
         first_src_q <= 1'b0;
         sync_seen   <= 1'b0;
      end else begin
         dist_q      <= dist_clk;
         // Cleared during sync so the second stage restarts on a clean edge
         first_src_q <= sync_hold ? 1'b0 : first_src;
         sync_seen   <= sync_hold;
      end
   end

   // First stage counts rising edges of the distribution clock
   always @(posedge aclk) begin
      if (!aresetn) begin
         first_level <= 1'b0;
         first_count <= 5'h00;
      end else if (sync_hold) begin
         {first_level, first_count} <= first_init;
      end else if (bypass_first) begin
         // Bypassed: counter idles at zero, level kept
         first_count <= 5'h00;
      end else if (dist_rise) begin
         {first_level, first_count} <= first_next;
      end
   end

   // Second stage counts rising edges of the first stage output
   always @(posedge aclk) begin
      if (!aresetn) begin
         second_level <= 1'b0;
         second_count <= 5'h00;
      end else if (sync_hold) begin
         {second_level, second_count} <= second_init;
      end else if (bypass_second) begin
         // Bypassed: counter idles at zero, level kept
         second_count <= 5'h00;
      end else if (second_tick) begin
         {second_level, second_count} <= second_next;
      end
   end

   // Force overrides the divided output only when sync is ignored
   always @(posedge aclk) begin
      if (!aresetn) begin
         channel_out <= 1'b0;
      end else if (ignore_sync) begin
         channel_out <= force_level;
      end else begin
         channel_out <= second_src;
      end
   end

   // Correction is only reported; the waveform is not reshaped
   always @(posedge aclk) begin
      if (!aresetn) begin
         duty_correction_active <= 1'b0;
      end else begin
         duty_correction_active <= ~duty_correction_disable;
      end
   end

   // AXI4-Lite slave; write address and data are taken together
   reg  [31:0] next_rdata;
   reg  [1:0]  next_rresp;
   // A new write waits until the previous answer is taken
   wire       wr_go  = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
   // A new read waits until the previous read data is taken
   wire       rd_go  = s_axi_arvalid & ~s_axi_rvalid;
   wire [9:0] wr_idx = s_axi_awaddr[11:2];
   wire [9:0] rd_idx = s_axi_araddr[11:2];
   wire       wr_lane0 = wr_go & s_axi_wstrb[0];
   // Per-register write enables
   wire       wr_first_counts  = wr_lane0 & (wr_idx == `IDX_FIRST_STAGE_CYCLE_COUNTS);
   wire       wr_phase         = wr_lane0 & (wr_idx == `IDX_STAGE_PHASE_OFFSETS);
   wire       wr_second_counts = wr_lane0 & (wr_idx == `IDX_SECOND_STAGE_CYCLE_COUNTS);
   wire       wr_control       = wr_lane0 & (wr_idx == `IDX_CHANNEL_DIVIDER_CONTROL);
   wire       wr_duty          = wr_lane0 & (wr_idx == `IDX_DUTY_CORRECTION_CONTROL);

   assign s_axi_awready = wr_go;
   assign s_axi_wready  = wr_go;
   assign s_axi_arready = rd_go;

   // Register stores; only byte lane 0 carries data
   always @(posedge aclk) begin
      if (!aresetn) begin
         first_stage_cycle_counts <= `RST_CYCLE_COUNTS;
      end else if (wr_first_counts) begin
         first_stage_cycle_counts <= s_axi_wdata[7:0];
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         stage_phase_offsets <= `RST_PHASE_OFFSETS;
      end else if (wr_phase) begin
         stage_phase_offsets <= s_axi_wdata[7:0];
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         second_stage_cycle_counts <= `RST_CYCLE_COUNTS;
      end else if (wr_second_counts) begin
         second_stage_cycle_counts <= s_axi_wdata[7:0];
      end
   end

   // Control bits 7:6 are not implemented and read as zero
   always @(posedge aclk) begin
      if (!aresetn) begin
         channel_divider_control <= `RST_CONTROL;
      end else if (wr_control) begin
         channel_divider_control <= {2'h0, s_axi_wdata[5:0]};
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         duty_correction_control <= `RST_DUTY_CORRECTION;
      end else if (wr_duty) begin
         duty_correction_control <= {7'h00, s_axi_wdata[0]};
      end
   end

   // Write answer stands until the master takes it
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= mapped(wr_idx) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Read data selection; unmapped indices read zero with an error answer
   always @* begin
      next_rresp = mapped(rd_idx) ? `RESP_OKAY : `RESP_SLVERR;
      case (rd_idx)
         `IDX_FIRST_STAGE_CYCLE_COUNTS:  next_rdata = reg_word(first_stage_cycle_counts);
         `IDX_STAGE_PHASE_OFFSETS:       next_rdata = reg_word(stage_phase_offsets);
         `IDX_SECOND_STAGE_CYCLE_COUNTS: next_rdata = reg_word(second_stage_cycle_counts);
         `IDX_CHANNEL_DIVIDER_CONTROL:   next_rdata = reg_word(channel_divider_control);
         `IDX_DUTY_CORRECTION_CONTROL:   next_rdata = reg_word(duty_correction_control);
         `IDX_CHANNEL_STATUS:            next_rdata = {28'h0000000, status_bits};
         default:                        next_rdata = 32'h00000000;
      endcase
   end

   // Read answer stands until the master takes it
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= `RESP_OKAY;
      end else if (rd_go) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= next_rdata;
         s_axi_rresp  <= next_rresp;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule

// >>> inc/cascaded_channel_divider_map.vh
// Register indices, field positions and reset values of the cascaded channel divider
`ifndef CASCADED_CHANNEL_DIVIDER_MAP_VH
`define CASCADED_CHANNEL_DIVIDER_MAP_VH

// Register indices; byte address is four times the index
`define IDX_FIRST_STAGE_CYCLE_COUNTS  10'h19E
`define IDX_STAGE_PHASE_OFFSETS       10'h19F
`define IDX_SECOND_STAGE_CYCLE_COUNTS 10'h1A0
`define IDX_CHANNEL_DIVIDER_CONTROL   10'h1A1
`define IDX_DUTY_CORRECTION_CONTROL   10'h1A2
`define IDX_CHANNEL_STATUS            10'h1A3

// Field positions
`define LOW_FIELD_MSB        7
`define LOW_FIELD_LSB        4
`define HIGH_FIELD_MSB       3
`define HIGH_FIELD_LSB       0
`define BIT_BYPASS_SECOND    5
`define BIT_BYPASS_FIRST     4
`define BIT_IGNORE_SYNC      3
`define BIT_FORCE_LEVEL      2
`define BIT_START_HIGH_2ND   1
`define BIT_START_HIGH_1ST   0
`define BIT_DUTY_CORR_DIS    0

// Reset values
`define RST_CYCLE_COUNTS     8'h00
`define RST_PHASE_OFFSETS    8'h00
`define RST_CONTROL          8'h00
`define RST_DUTY_CORRECTION  8'h00

// Bus answers
`define RESP_OKAY            2'h0
`define RESP_SLVERR          2'h2

`endif

// >>> verif/cascaded_channel_divider_chk.sv
// Checker for bus answers and channel output of the cascaded channel divider
`include "cascaded_channel_divider_map.vh"
module cascaded_channel_divider_chk (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0]  s_axi_wstrb,
   input wire logic        s_axi_wvalid,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_arvalid,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        sync_req,
   input wire logic        channel_out,
   input wire logic        duty_correction_active
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] ctl;
   logic [7:0] dcc;
   wire        take_w = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
   wire [9:0]  widx = s_axi_awaddr[11:2];
   wire        unmapped = widx < `IDX_FIRST_STAGE_CYCLE_COUNTS || widx > `IDX_CHANNEL_STATUS;
   // Shadow of the control and correction registers
   always @(posedge aclk) begin
      if (!aresetn) begin
         ctl <= 8'h00;
         dcc <= 8'h00;
      end else if (take_w && s_axi_wstrb[0]) begin
         if (widx == `IDX_CHANNEL_DIVIDER_CONTROL) ctl <= s_axi_wdata[7:0];
         if (widx == `IDX_DUTY_CORRECTION_CONTROL) dcc <= s_axi_wdata[7:0];
      end
   end
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_write_answer: assert property (take_w |=> s_axi_bvalid && s_axi_bresp == (unmapped ? 2'h2 : 2'h0))
      else $error("write answer wrong");
   a_read_answer: assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid) else $error("read not answered");
   a_read_clears: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid stuck");
   a_no_write_pending: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("write taken while pending");
   a_rdata_narrow: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("rdata upper bits set");
   a_duty_flag: assert property ($stable(dcc) [*3] |-> duty_correction_active == !dcc[0])
      else $error("duty flag wrong");
   a_force_level: assert property ((ctl[3] && $stable(ctl)) [*3] |-> channel_out == ctl[2])
      else $error("forced level wrong");
   a_sync_start: assert property ((!ctl[3] && !ctl[5] && sync_req && $stable(ctl)) [*4] |-> channel_out == ctl[1])
      else $error("start level wrong");
   cover property (ctl[3] && ctl[2] && channel_out);
   cover property (sync_req && !ctl[3]);
   cover property (take_w && unmapped);
endmodule
bind cascaded_channel_divider cascaded_channel_divider_chk chk_i (.*);

// >>> verif/cascaded_channel_divider_tb.sv
// Self-checking testbench for the cascaded channel divider
`include "cascaded_channel_divider_map.vh"
module cascaded_channel_divider_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, sync_req, channel_out;
   logic        dist_clk = 1'b0;
   logic        duty_correction_active;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [1:0]  ph = 2'h0;
   int          errors, n_checks;
   int          cyc = 0;
   int          dcnt = 0;
   cascaded_channel_divider DUT (.*);
   initial begin
      aclk = 0;
      forever #50 aclk = ~aclk;
   end
   // Divider input at a quarter of aclk, with a count of its rising edges
   always @(posedge aclk) begin
      ph <= ph + 2'h1;
      dist_clk <= ph[1];
      if (ph == 2'h1) dcnt <= dcnt + 1;
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         errors++;
         final_report;
      end
   end
   task chk(string nm, logic [31:0] seen, logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task final_report;
      $display("errors %0d checks %0d", errors, n_checks);
      if (errors == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task wr(logic [9:0] i, logic [7:0] d, logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr <= {i, 2'h0};
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do @(posedge aclk); while (s_axi_awready !== 1'b1);
      s_axi_awvalid <= 0;
      s_axi_wvalid <= 0;
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      chk("bresp", s_axi_bresp, er);
      s_axi_bready <= 0;
   endtask
   task rd(logic [9:0] i, logic [7:0] d, logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= {i, 2'h0};
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      chk("rdata", s_axi_rdata, {24'h0, d});
      chk("rresp", s_axi_rresp, er);
      s_axi_rready <= 0;
   endtask
   task wait_lvl(logic v);
      do @(posedge aclk); while (channel_out !== v);
   endtask
   task measure(logic [7:0] c, int hi, int lo);
      int t0;
      int t1;
      wr(`IDX_CHANNEL_DIVIDER_CONTROL, c, `RESP_OKAY);
      wait_lvl(0);
      wait_lvl(1);
      t0 = dcnt;
      wait_lvl(0);
      t1 = dcnt;
      wait_lvl(1);
      chk("high span", t1 - t0, hi);
      chk("low span", dcnt - t1, lo);
   endtask
   task sync_start(logic [7:0] c, logic e);
      wr(`IDX_CHANNEL_DIVIDER_CONTROL, c, `RESP_OKAY);
      sync_req <= 1;
      repeat (5) @(posedge aclk);
      chk("sync level", channel_out, e);
      sync_req <= 0;
   endtask
   task sync_status(logic [7:0] c, logic [3:0] s);
      wr(`IDX_CHANNEL_DIVIDER_CONTROL, c, `RESP_OKAY);
      sync_req <= 1;
      repeat (3) @(posedge aclk);
      rd(`IDX_CHANNEL_STATUS, {4'h0, s}, `RESP_OKAY);
      sync_req <= 0;
   endtask
   task force_level(logic [7:0] c, logic e);
      sync_start(c, e);
      repeat (20) @(posedge aclk);
      chk("static level", channel_out, e);
   endtask
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, sync_req} = 0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, errors, n_checks} = 0;
      s_axi_wstrb = 4'hF;
      aresetn = 0;
      repeat (6) @(posedge aclk);
      aresetn <= 1;
      for (int i = 0; i < 4; i++) rd(10'(`IDX_STAGE_PHASE_OFFSETS + i), 8'h00, `RESP_OKAY);
      chk("duty flag", duty_correction_active, 1'b1);
      wr(`IDX_STAGE_PHASE_OFFSETS, 8'hA5, `RESP_OKAY);
      rd(`IDX_STAGE_PHASE_OFFSETS, 8'hA5, `RESP_OKAY);
      wr(`IDX_STAGE_PHASE_OFFSETS, 8'h00, `RESP_OKAY);
      wr(`IDX_CHANNEL_DIVIDER_CONTROL, 8'hFF, `RESP_OKAY);
      rd(`IDX_CHANNEL_DIVIDER_CONTROL, 8'h3F, `RESP_OKAY);
      wr(`IDX_DUTY_CORRECTION_CONTROL, 8'h01, `RESP_OKAY);
      repeat (3) @(posedge aclk);
      chk("duty flag", duty_correction_active, 1'b0);
      wr(`IDX_DUTY_CORRECTION_CONTROL, 8'h00, `RESP_OKAY);
      wr(10'h100, 8'h55, `RESP_SLVERR);
      rd(10'h100, 8'h00, `RESP_SLVERR);
      wr(`IDX_FIRST_STAGE_CYCLE_COUNTS, 8'h10, `RESP_OKAY);
      wr(`IDX_SECOND_STAGE_CYCLE_COUNTS, 8'h21, `RESP_OKAY);
      measure(8'h00, 6, 9);
      measure(8'h10, 2, 3);
      measure(8'h20, 1, 2);
      sync_start(8'h02, 1'b1);
      sync_start(8'h00, 1'b0);
      sync_start(8'h21, 1'b1);
      sync_start(8'h20, 1'b0);
      sync_status(8'h02, 4'hD);
      sync_status(8'h21, 4'hF);
      force_level(8'h0C, 1'b1);
      force_level(8'h08, 1'b0);
      final_report;
   end
endmodule
